// *** design/pfb_pin_function.sv ***
// Pin function control: thermistor bias, charger control and battery presence.
// Assumes an APB master on pclk and gauge-core inputs on the same clock.
`timescale 1ns/1ps
module pfb_pin_function #(
	parameter int unsigned TICK_CYCLES = pfb_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  logic                            pclk,
	input  logic                            presetn,
	// APB slave
	input  logic                            psel,
	input  logic                            penable,
	input  logic                            pwrite,
	input  logic [7:0]                      paddr,
	input  logic [31:0]                     pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Gauge core
	input  pfb_pkg::pfb_mode_type           gauge_mode,
	input  logic                            fully_charged_flag,
	input  logic [pfb_pkg::TEMP_W-1:0]      cell_temp,
	input  logic [pfb_pkg::ADC_W-1:0]       therm_adc,
	input  logic                            presence_check_req,
	// Battery insert pin
	input  logic                            battery_insert_pin_in,
	output logic                            battery_insert_pin_out,
	output logic                            battery_insert_pin_oe_n,
	// Charger and status
	output logic                            charger_control_out,
	output logic                            battery_present_flag,
	output logic                            irq
);
	// ==========================================================
	// Declarations
	logic                       ms_tick, sec_tick, sleep_slot;
	logic                       pin_meta_q, pin_sync_q;
	logic [1:0]                 pin_config_select_q, pin_config_select_d;
	logic                       external_thermistor_select_q, external_thermistor_select_d;
	logic                       insertion_detect_enable_q, insertion_detect_enable_d;
	logic [pfb_pkg::TEMP_W-1:0] tlim_low_q, tlim_low_d, tlim_high_q, tlim_high_d;
	logic [pfb_pkg::ADC_W-1:0]  disc_q, disc_d;
	logic [pfb_pkg::INT_W-1:0]  int_status_q, int_status_d, int_mask_q, int_mask_d, int_set;
	logic [31:0]                prdata_d, rd_word;
	logic                       addr_hit, wr_en, host_insert_cmd, host_remove_cmd;
	pfb_pkg::pfb_seq_type       seq_q, seq_d;
	logic [7:0]                 cnt_q, cnt_d;
	logic                       bias_due_q, bias_due_d, init_q, init_d;
	logic                       present_q, present_d;
	logic                       bias_due, start;
	logic                       ev_meas;
	logic                       inhibit_q, inhibit_d, chg_out_q, chg_out_d;

	pfb_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.pclk      (pclk),
		.presetn   (presetn),
		.ms_tick   (ms_tick),
		.sec_tick  (sec_tick),
		.sleep_slot(sleep_slot)
	);

	// ==========================================================
	// Pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			pin_meta_q <= battery_insert_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================================
	// APB registers and interrupt
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;

	always_comb begin
		addr_hit = 1'b1;
		rd_word  = '0;
		unique case (paddr)
			pfb_pkg::CFG_OFFSET: begin
				rd_word[pfb_pkg::CFG_PFC_LSB +: 2]    = pin_config_select_q;
				rd_word[pfb_pkg::CFG_THERM_BIT]       = external_thermistor_select_q;
				rd_word[pfb_pkg::CFG_DETECT_BIT]      = insertion_detect_enable_q;
			end
			pfb_pkg::CMD_OFFSET: begin
				rd_word = '0;
			end
			pfb_pkg::STATUS_OFFSET: begin
				rd_word[pfb_pkg::ST_PRESENT_BIT] = present_q;
				rd_word[pfb_pkg::ST_INHIBIT_BIT] = inhibit_q;
				rd_word[pfb_pkg::ST_CHGOUT_BIT]  = chg_out_q;
				rd_word[pfb_pkg::ST_BIAS_BIT]    = (seq_q == pfb_pkg::SEQ_BIAS);
				rd_word[pfb_pkg::ST_FULL_BIT]    = fully_charged_flag;
			end
			pfb_pkg::TLIM_OFFSET: begin
				rd_word = {tlim_high_q, tlim_low_q};
			end
			pfb_pkg::DISC_OFFSET: begin
				rd_word[pfb_pkg::ADC_W-1:0] = disc_q;
			end
			pfb_pkg::INT_STATUS_OFFSET: begin
				rd_word[pfb_pkg::INT_W-1:0] = int_status_q;
			end
			pfb_pkg::INT_MASK_OFFSET: begin
				rd_word[pfb_pkg::INT_W-1:0] = int_mask_q;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	assign pslverr = psel && penable && !addr_hit;

	always_comb begin
		prdata_d                     = prdata;
		pin_config_select_d          = pin_config_select_q;
		external_thermistor_select_d = external_thermistor_select_q;
		insertion_detect_enable_d    = insertion_detect_enable_q;
		tlim_low_d                   = tlim_low_q;
		tlim_high_d                  = tlim_high_q;
		disc_d                       = disc_q;
		int_mask_d                   = int_mask_q;
		host_insert_cmd              = 1'b0;
		host_remove_cmd              = 1'b0;
		int_status_d                 = int_status_q;
		if (psel && !penable) begin
			prdata_d = pwrite ? 32'h0000_0000 : rd_word;
		end
		if (wr_en && paddr == pfb_pkg::CFG_OFFSET) begin
			pin_config_select_d          = pwdata[pfb_pkg::CFG_PFC_LSB +: 2];
			external_thermistor_select_d = pwdata[pfb_pkg::CFG_THERM_BIT];
			insertion_detect_enable_d    = pwdata[pfb_pkg::CFG_DETECT_BIT];
		end
		if (wr_en && paddr == pfb_pkg::CMD_OFFSET) begin
			host_insert_cmd = pwdata[pfb_pkg::CMD_INSERT_BIT];
			host_remove_cmd = pwdata[pfb_pkg::CMD_REMOVE_BIT];
		end
		if (wr_en && paddr == pfb_pkg::TLIM_OFFSET) begin
			tlim_low_d  = pwdata[pfb_pkg::TEMP_W-1:0];
			tlim_high_d = pwdata[pfb_pkg::TLIM_HIGH_LSB +: pfb_pkg::TEMP_W];
		end
		if (wr_en && paddr == pfb_pkg::DISC_OFFSET) begin
			disc_d = pwdata[pfb_pkg::ADC_W-1:0];
		end
		if (wr_en && paddr == pfb_pkg::INT_MASK_OFFSET) begin
			int_mask_d = pwdata[pfb_pkg::INT_W-1:0];
		end
		if (wr_en && paddr == pfb_pkg::INT_STATUS_OFFSET) begin
			int_status_d = int_status_q & ~pwdata[pfb_pkg::INT_W-1:0];
		end
		// New events win over a clear in the same cycle
		int_status_d = int_status_d | int_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata                       <= '0;
			pin_config_select_q          <= pfb_pkg::PFC_RESET;
			external_thermistor_select_q <= pfb_pkg::THERM_RESET;
			insertion_detect_enable_q    <= pfb_pkg::DETECT_RESET;
			tlim_low_q                   <= pfb_pkg::TLIM_LOW_RESET;
			tlim_high_q                  <= pfb_pkg::TLIM_HIGH_RESET;
			disc_q                       <= pfb_pkg::DISC_RESET;
			int_mask_q                   <= pfb_pkg::INT_MASK_RESET;
			int_status_q                 <= '0;
		end else begin
			prdata                       <= prdata_d;
			pin_config_select_q          <= pin_config_select_d;
			external_thermistor_select_q <= external_thermistor_select_d;
			insertion_detect_enable_q    <= insertion_detect_enable_d;
			tlim_low_q                   <= tlim_low_d;
			tlim_high_q                  <= tlim_high_d;
			disc_q                       <= disc_d;
			int_mask_q                   <= int_mask_d;
			int_status_q                 <= int_status_d;
		end
	end

	assign irq = |(int_status_q & int_mask_q);

	// ==========================================================
	// Bias schedule and presence sequencer
	always_comb begin
		bias_due = 1'b0;
		if (external_thermistor_select_q) begin
			if (pin_config_select_q != pfb_pkg::PFC_CONFIG2) begin
				bias_due = 1'b1;
			end else begin
				unique case (gauge_mode)
					pfb_pkg::MODE_DISCHARGE: bias_due = 1'b1;
					pfb_pkg::MODE_RELAX:     bias_due = 1'b1;
					pfb_pkg::MODE_CHARGE:    bias_due = 1'b0;
					pfb_pkg::MODE_SLEEP:     bias_due = sleep_slot;
				endcase
			end
		end
	end

	assign start = sec_tick || presence_check_req || init_q;

	always_comb begin
		seq_d      = seq_q;
		cnt_d      = cnt_q;
		bias_due_d = bias_due_q;
		init_d     = init_q;
		present_d  = present_q;
		ev_meas    = 1'b0;
		unique case (seq_q)
			pfb_pkg::SEQ_IDLE: begin
				if (start) begin
					init_d     = 1'b0;
					bias_due_d = bias_due;
					if (insertion_detect_enable_q) begin
						seq_d = pfb_pkg::SEQ_SETTLE;
						cnt_d = 8'(pfb_pkg::SETTLE_TIME_MS);
					end else if (bias_due) begin
						seq_d = pfb_pkg::SEQ_BIAS;
						cnt_d = 8'(pfb_pkg::BIAS_TIME_MS);
					end
				end
			end
			pfb_pkg::SEQ_SETTLE: begin
				if (ms_tick) begin
					cnt_d = cnt_q - 8'h01;
					if (cnt_q == 8'h01) begin
						seq_d = pfb_pkg::SEQ_SAMPLE;
					end
				end
			end
			pfb_pkg::SEQ_SAMPLE: begin
				if (insertion_detect_enable_q) begin
					present_d = !pin_sync_q;
				end
				if (bias_due_q) begin
					seq_d = pfb_pkg::SEQ_BIAS;
					cnt_d = 8'(pfb_pkg::BIAS_TIME_MS);
				end else begin
					seq_d = pfb_pkg::SEQ_IDLE;
				end
			end
			pfb_pkg::SEQ_BIAS: begin
				if (ms_tick) begin
					cnt_d = cnt_q - 8'h01;
					if (cnt_q == 8'h01) begin
						seq_d   = pfb_pkg::SEQ_IDLE;
						ev_meas = 1'b1;
						if (insertion_detect_enable_q && therm_adc >= disc_q) begin
							present_d = 1'b0;
						end
					end
				end
			end
		endcase
		if (!insertion_detect_enable_q) begin
			if (host_insert_cmd) begin
				present_d = 1'b1;
			end
			if (host_remove_cmd) begin
				present_d = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_q      <= pfb_pkg::SEQ_IDLE;
			cnt_q      <= '0;
			bias_due_q <= 1'b0;
			init_q     <= 1'b1;
			present_q  <= 1'b0;
		end else begin
			seq_q      <= seq_d;
			cnt_q      <= cnt_d;
			bias_due_q <= bias_due_d;
			init_q     <= init_d;
			present_q  <= present_d;
		end
	end

	// Pin drives high only while biasing, otherwise it floats
	assign battery_insert_pin_out  = (seq_q == pfb_pkg::SEQ_BIAS);
	assign battery_insert_pin_oe_n = (seq_q != pfb_pkg::SEQ_BIAS);
	assign battery_present_flag    = present_q;

	// ==========================================================
	// Charger control output
	always_comb begin
		inhibit_d = (cell_temp < tlim_low_q) || (cell_temp > tlim_high_q);
		unique case (pin_config_select_q)
			pfb_pkg::PFC_CONFIG1: chg_out_d = inhibit_q;
			pfb_pkg::PFC_CONFIG3: chg_out_d = fully_charged_flag;
			pfb_pkg::PFC_CONFIG0: chg_out_d = 1'b0;
			pfb_pkg::PFC_CONFIG2: chg_out_d = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inhibit_q <= 1'b0;
			chg_out_q <= 1'b0;
		end else begin
			inhibit_q <= inhibit_d;
			chg_out_q <= chg_out_d;
		end
	end

	assign charger_control_out = chg_out_q;

	// ==========================================================
	// Interrupt events
	always_comb begin
		int_set                           = '0;
		int_set[pfb_pkg::INT_INSERT_BIT]  = present_d && !present_q;
		int_set[pfb_pkg::INT_REMOVE_BIT]  = !present_d && present_q;
		int_set[pfb_pkg::INT_INHIBIT_BIT] = inhibit_d != inhibit_q;
		int_set[pfb_pkg::INT_MEAS_BIT]    = ev_meas;
	end

endmodule

// *** design/pfb_pkg.sv ***
// Constants, field positions and types shared by the pin-function block.
// Assumes a 100 MHz pclk and an APB master that uses byte addresses.
// How it works
// - Two-bit code selects pin configuration 0..3
// - Thermistor select enables periodic 125 ms bias
// - Config 1: inhibit charging outside temperature range
// - Config 3: charger output mirrors fully-charged flag
// - Configs 0 and 2: charger output unused
// - Release insert pin to high-Z before sampling
// - Sample pin each second; low means present
// - Thermistor voltage near pull-up means disconnected
// - Detection disabled: host commands give presence
// - Insert command sets, remove command clears flag
package pfb_pkg;

	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] CFG_OFFSET        = 8'h00;
	localparam logic [7:0] CMD_OFFSET        = 8'h04;
	localparam logic [7:0] STATUS_OFFSET     = 8'h08;
	localparam logic [7:0] TLIM_OFFSET       = 8'h0c;
	localparam logic [7:0] DISC_OFFSET       = 8'h10;
	localparam logic [7:0] INT_STATUS_OFFSET = 8'h14;
	localparam logic [7:0] INT_MASK_OFFSET   = 8'h18;

	// ==========================================================
	// Field positions
	localparam int unsigned CFG_PFC_LSB     = 0;
	localparam int unsigned CFG_THERM_BIT   = 2;
	localparam int unsigned CFG_DETECT_BIT  = 3;
	localparam int unsigned CMD_INSERT_BIT  = 0;
	localparam int unsigned CMD_REMOVE_BIT  = 1;
	localparam int unsigned ST_PRESENT_BIT  = 0;
	localparam int unsigned ST_INHIBIT_BIT  = 1;
	localparam int unsigned ST_CHGOUT_BIT   = 2;
	localparam int unsigned ST_BIAS_BIT     = 3;
	localparam int unsigned ST_FULL_BIT     = 4;
	localparam int unsigned TLIM_HIGH_LSB   = 16;
	localparam int unsigned INT_INSERT_BIT  = 0;
	localparam int unsigned INT_REMOVE_BIT  = 1;
	localparam int unsigned INT_INHIBIT_BIT = 2;
	localparam int unsigned INT_MEAS_BIT    = 3;
	localparam int unsigned INT_W           = 4;
	localparam int unsigned TEMP_W          = 16;
	localparam int unsigned ADC_W           = 12;

	// ==========================================================
	// Reset values
	localparam logic [1:0]        PFC_RESET       = 2'h0;
	localparam logic              THERM_RESET     = 1'b0;
	localparam logic              DETECT_RESET    = 1'b1;
	localparam logic [TEMP_W-1:0] TLIM_LOW_RESET  = 16'h0000;
	localparam logic [TEMP_W-1:0] TLIM_HIGH_RESET = 16'hffff;
	localparam logic [ADC_W-1:0]  DISC_RESET      = 12'hf00;
	localparam logic [INT_W-1:0]  INT_MASK_RESET  = 4'h0;

	// ==========================================================
	// Pin function codes
	localparam logic [1:0] PFC_CONFIG0 = 2'b00;
	localparam logic [1:0] PFC_CONFIG1 = 2'b01;
	localparam logic [1:0] PFC_CONFIG2 = 2'b10;
	localparam logic [1:0] PFC_CONFIG3 = 2'b11;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned POLL_PERIOD_MS = 1000;
	localparam int unsigned SLEEP_POLL_S   = 20;
	localparam int unsigned BIAS_TIME_MS   = 125;
	localparam int unsigned SETTLE_TIME_MS = 2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_DISCHARGE = 2'b00,
		MODE_RELAX     = 2'b01,
		MODE_CHARGE    = 2'b10,
		MODE_SLEEP     = 2'b11
	} pfb_mode_type;

	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_SETTLE = 2'b01,
		SEQ_SAMPLE = 2'b10,
		SEQ_BIAS   = 2'b11
	} pfb_seq_type;

endpackage

// *** design/pfb_timebase.sv ***
// Millisecond, one-second and twenty-second enable pulses.
// Assumes one free-running pclk; all pulses last one cycle.
`timescale 1ns/1ps
module pfb_timebase #(
	parameter int unsigned TICK_CYCLES = pfb_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  logic pclk,
	input  logic presetn,
	// Enables
	output logic ms_tick,
	output logic sec_tick,
	output logic sleep_slot
);
	localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

	logic [CW-1:0] cyc_q, cyc_d;
	logic [9:0]    ms_q, ms_d;
	logic [4:0]    sec_q, sec_d;
	logic          ms_tick_d, sec_tick_d, slot_d;

	// ==========================================================
	// Dividers
	always_comb begin
		cyc_d      = cyc_q + CW'(1);
		ms_d       = ms_q;
		sec_d      = sec_q;
		ms_tick_d  = 1'b0;
		sec_tick_d = 1'b0;
		slot_d     = 1'b0;
		if (cyc_q == CW'(TICK_CYCLES - 1)) begin
			cyc_d     = '0;
			ms_tick_d = 1'b1;
			ms_d      = ms_q + 10'h001;
			if (ms_q == 10'(pfb_pkg::POLL_PERIOD_MS - 1)) begin
				ms_d       = '0;
				sec_tick_d = 1'b1;
				sec_d      = sec_q + 5'h01;
				if (sec_q == 5'(pfb_pkg::SLEEP_POLL_S - 1)) begin
					sec_d  = '0;
					slot_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q      <= '0;
			ms_q       <= '0;
			sec_q      <= '0;
			ms_tick    <= 1'b0;
			sec_tick   <= 1'b0;
			sleep_slot <= 1'b0;
		end else begin
			cyc_q      <= cyc_d;
			ms_q       <= ms_d;
			sec_q      <= sec_d;
			ms_tick    <= ms_tick_d;
			sec_tick   <= sec_tick_d;
			sleep_slot <= slot_d;
		end
	end

endmodule

// *** dv/pfb_pack_model.sv ***
// Battery pack model: insert pin pull-up or cell pull-down, thermistor voltage.
// Assumes the block drives the pin only while its enable is low.
`timescale 1ns/1ps
module pfb_pack_model (
	// Clock
	input  logic        pclk,
	// Pack state
	input  logic        battery_in,
	input  logic        therm_open,
	// Insert pin and thermistor
	input  logic        pin_out,
	input  logic        pin_oe_n,
	output logic        pin_in,
	output logic [11:0] adc
);
	logic       flip = 1'b0;
	logic [1:0] hold_q = 2'h0;
	logic       live;
	always_ff @(posedge pclk) begin
		flip   <= ~flip;
		hold_q <= {hold_q[0], !pin_oe_n};
	end
	// Released pin: low with a cell fitted, else the pull-up holds it high
	assign pin_in = !pin_oe_n ? pin_out : !battery_in;
	// Reading holds briefly after bias, then turns to junk
	assign live = !pin_oe_n || (|hold_q);
	assign adc  = live ? (therm_open ? 12'hffe : 12'h400) : {6{flip, ~flip}};
endmodule

// *** dv/pfb_pin_function_asserts.sv ***
// Port checker for the pin-function block.
// Assumes a bind into pfb_pin_function; config and limits are tracked from APB writes.
`timescale 1ns/1ps
module pfb_pin_chk #(
	parameter int unsigned TICK_CYCLES = pfb_pkg::TICK_CYCLES
) (
	// Clock, reset and APB
	input logic                  pclk,
	input logic                  presetn,
	input logic                  psel,
	input logic                  penable,
	input logic                  pwrite,
	input logic [7:0]            paddr,
	input logic [31:0]           pwdata,
	// Gauge core
	input pfb_pkg::pfb_mode_type gauge_mode,
	input logic                  fully_charged_flag,
	input logic [15:0]           cell_temp,
	// Pins and status
	input logic                  battery_insert_pin_out,
	input logic                  battery_insert_pin_oe_n,
	input logic                  charger_control_out,
	input logic                  battery_present_flag
);
	// ==========================================================
	// Helper state
	localparam int unsigned BIAS_MIN = 124 * TICK_CYCLES;
	localparam int unsigned BIAS_MAX = 126 * TICK_CYCLES;
	logic [3:0]  cfg_q, cfg_d;
	logic [31:0] tlim_q, tlim_d;
	logic [1:0]  age_q, age_d;
	logic [31:0] low_q, low_d, high_q, high_d;
	logic        wr, out_rng;
	always_comb begin
		wr      = psel && penable && pwrite;
		cfg_d   = (wr && paddr == pfb_pkg::CFG_OFFSET) ? pwdata[3:0] : cfg_q;
		tlim_d  = (wr && paddr == pfb_pkg::TLIM_OFFSET) ? pwdata : tlim_q;
		age_d   = wr ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
		low_d   = battery_insert_pin_oe_n ? 32'h0 : low_q + 32'h1;
		high_d  = !battery_insert_pin_oe_n ? 32'h0 : high_q + {31'h0, high_q != 32'hffff_ffff};
		out_rng = cell_temp < tlim_q[15:0] || cell_temp > tlim_q[31:16];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q  <= {pfb_pkg::DETECT_RESET, pfb_pkg::THERM_RESET, pfb_pkg::PFC_RESET};
			tlim_q <= {pfb_pkg::TLIM_HIGH_RESET, pfb_pkg::TLIM_LOW_RESET};
			age_q  <= 2'h0;
			low_q  <= 32'h0;
			high_q <= 32'h0;
		end else begin
			cfg_q  <= cfg_d;
			tlim_q <= tlim_d;
			age_q  <= age_d;
			low_q  <= low_d;
			high_q <= high_d;
		end
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_bias_drive: assert property (!battery_insert_pin_oe_n |-> battery_insert_pin_out)
		else $error("insert pin not driven high during bias");
	a_bias_length: assert property ($rose(battery_insert_pin_oe_n) |-> low_q >= BIAS_MIN && low_q <= BIAS_MAX)
		else $error("bias length wrong");
	a_bias_select: assert property ($fell(battery_insert_pin_oe_n) |-> cfg_q[2])
		else $error("bias without thermistor select");
	a_no_charge_bias: assert property ($fell(battery_insert_pin_oe_n) |->
		!(cfg_q[1:0] == pfb_pkg::PFC_CONFIG2 && gauge_mode == pfb_pkg::MODE_CHARGE))
		else $error("bias during charge in config 2");
	a_release_first: assert property ($fell(battery_insert_pin_oe_n) && cfg_q[3] |-> high_q >= TICK_CYCLES)
		else $error("pin not released before sample");
	a_chg_inhibit: assert property (cfg_q[1:0] == pfb_pkg::PFC_CONFIG1 && age_q == 2'h3 |->
		charger_control_out == $past(out_rng, 2))
		else $error("charge inhibit wrong");
	a_chg_full: assert property (cfg_q[1:0] == pfb_pkg::PFC_CONFIG3 && age_q == 2'h3 |->
		charger_control_out == $past(fully_charged_flag))
		else $error("charger output not following full flag");
	a_chg_unused: assert property ((cfg_q[1:0] == pfb_pkg::PFC_CONFIG0 || cfg_q[1:0] == pfb_pkg::PFC_CONFIG2)
		&& age_q == 2'h3 |-> !charger_control_out)
		else $error("charger output used in config 0 or 2");
	a_cmd_remove: assert property (wr && paddr == pfb_pkg::CMD_OFFSET && !cfg_q[3] && pwdata[1]
		|=> !battery_present_flag)
		else $error("remove command did not clear presence");
	a_cmd_insert: assert property (wr && paddr == pfb_pkg::CMD_OFFSET && !cfg_q[3] && pwdata[1:0] == 2'b01
		|=> battery_present_flag)
		else $error("insert command did not set presence");
endmodule

bind pfb_pin_function pfb_pin_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .gauge_mode(gauge_mode), .fully_charged_flag(fully_charged_flag),
	.cell_temp(cell_temp), .battery_insert_pin_out(battery_insert_pin_out),
	.battery_insert_pin_oe_n(battery_insert_pin_oe_n), .charger_control_out(charger_control_out),
	.battery_present_flag(battery_present_flag)
);

// *** dv/test_pin_function_and_battery_presence.sv ***
// Self-checking bench for the pin-function block.
// Assumes the pack model on the insert pin and a 10-cycle millisecond.
`timescale 1ns/1ps
module test_pin_function_and_battery_presence;
	// ==========================================================
	// Signals
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [7:0]            paddr = 8'h00;
	logic [31:0]           pwdata = 32'h0;
	logic [31:0]           prdata, rdata;
	logic                  pready, pslverr, perr;
	logic                  fcf = 1'b0;
	logic                  req = 1'b0;
	logic                  batt = 1'b1;
	logic                  topen = 1'b0;
	logic [15:0]           temp = 16'h0150;
	logic [11:0]           adc;
	logic                  pin_in, pin_out, oe_n, chg, pres, irq;
	pfb_pkg::pfb_mode_type mode = pfb_pkg::MODE_DISCHARGE;
	int                    n_errors = 0;
	int                    checks = 0;
	int                    cyc = 0;
	int                    n;

	always #5 pclk = ~pclk;

	pfb_pin_function #(.TICK_CYCLES(10)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gauge_mode(mode), .fully_charged_flag(fcf), .cell_temp(temp), .therm_adc(adc),
		.presence_check_req(req), .battery_insert_pin_in(pin_in), .battery_insert_pin_out(pin_out),
		.battery_insert_pin_oe_n(oe_n), .charger_control_out(chg), .battery_present_flag(pres), .irq(irq)
	);
	pfb_pack_model pack (
		.pclk(pclk), .battery_in(batt), .therm_open(topen), .pin_out(pin_out), .pin_oe_n(oe_n),
		.pin_in(pin_in), .adc(adc)
	);

	// ==========================================================
	// Tasks
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdata = prdata;
		perr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdata, e);
	endtask
	task automatic wait_sig(input bit sel, input logic lv, input int mx, output int k);
		k = 0;
		while ((sel ? pres : oe_n) !== lv && k < mx) begin
			@(posedge pclk);
			k++;
		end
	endtask
	task automatic pulse;
		req <= 1'b1;
		@(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic bias_run(output int len);
		int k;
		wait_sig(0, 1'b1, 2000, k);
		pulse;
		wait_sig(0, 1'b0, 100, k);
		wait_sig(0, 1'b1, 2000, len);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			end_of_test;
		end
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 32'h8, "cfg");
		rd(8'h0c, 32'hffff0000, "tlim");
		rd(8'h10, 32'hf00, "disc");
		rd(8'h18, 32'h0, "mask");
		rd(8'h1c, 32'h0, "unmapped");
		chk("slverr", perr, 1'b1);
		wait_sig(1, 1'b1, 100, n);
		chk("present_boot", pres, 1'b1);
		rd(8'h14, 32'h1, "int_boot");
		apb(1'b1, 8'h14, 32'h1);
		$display("test reset done");
		apb(1'b1, 8'h18, 32'h1);
		batt <= 1'b0;
		wait_sig(1, 1'b0, 11000, n);
		chk("removed", pres, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		chk("int_remove", rdata & 32'h2, 32'h2);
		chk("irq_masked", irq, 1'b0);
		apb(1'b1, 8'h18, 32'h2);
		chk("irq_on", irq, 1'b1);
		apb(1'b1, 8'h14, 32'hf);
		chk("irq_clear", irq, 1'b0);
		rd(8'h14, 32'h0, "int_clear");
		batt <= 1'b1;
		pulse;
		wait_sig(1, 1'b1, 100, n);
		chk("reinsert", pres, 1'b1);
		$display("test presence done");
		apb(1'b1, 8'h00, 32'hc);
		bias_run(n);
		chk("bias_len", n >= 1240 && n <= 1260, 1'b1);
		topen <= 1'b1;
		bias_run(n);
		wait_sig(1, 1'b0, 10, n);
		chk("open_therm", pres, 1'b0);
		topen <= 1'b0;
		bias_run(n);
		chk("restored", pres, 1'b1);
		apb(1'b1, 8'h00, 32'he);
		mode <= pfb_pkg::MODE_CHARGE;
		pulse;
		wait_sig(0, 1'b0, 1400, n);
		chk("no_bias_chg", oe_n, 1'b1);
		mode <= pfb_pkg::MODE_DISCHARGE;
		bias_run(n);
		chk("bias_dis", n >= 1240 && n <= 1260, 1'b1);
		mode <= pfb_pkg::MODE_RELAX;
		bias_run(n);
		chk("bias_relax", n >= 1240 && n <= 1260, 1'b1);
		mode <= pfb_pkg::MODE_SLEEP;
		pulse;
		wait_sig(0, 1'b0, 200, n);
		chk("no_bias_sleep", oe_n, 1'b1);
		mode <= pfb_pkg::MODE_DISCHARGE;
		$display("test bias done");
		apb(1'b1, 8'h0c, 32'h02000100);
		for (int p = 0; p < 2; p++) begin
			fcf  <= p == 0;
			temp <= p == 0 ? 16'h0300 : 16'h0150;
			for (int c = 0; c < 4; c++) begin
				apb(1'b1, 8'h00, 32'h8 | c);
				repeat (3) @(posedge pclk);
				rd(8'h00, 32'h8 | c, "cfg_code");
				chk("chg_out", chg, p == 0 && c[0]);
				rd(8'h08, {27'h0, p == 0, 1'b0, p == 0 && c[0], p == 0, 1'b1}, "status");
			end
		end
		$display("test charger done");
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h18, 32'h3);
		apb(1'b1, 8'h14, 32'hf);
		apb(1'b1, 8'h04, 32'h2);
		chk("cmd_remove", pres, 1'b0);
		chk("irq_cmd", irq, 1'b1);
		rd(8'h14, 32'h2, "int_cmd");
		apb(1'b1, 8'h14, 32'hf);
		apb(1'b1, 8'h04, 32'h1);
		chk("cmd_insert", pres, 1'b1);
		apb(1'b1, 8'h04, 32'h3);
		chk("cmd_both", pres, 1'b0);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h8);
		apb(1'b1, 8'h04, 32'h2);
		chk("cmd_ignored", pres, 1'b1);
		$display("test host done");
		end_of_test;
	end
endmodule
